// file: core/rtc_bcd_counter.sv
// Purpose: one wrapping bcd calendar counter with software load
// Assumes: load and increment never both wanted; load wins
// Notes:   wrap is combinational and marks the step from hi back to lo
`timescale 1ns/100ps
module rtc_bcd_counter #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_inc,
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_val,
  input  wire logic [7:0] i_lo,
  input  wire logic [7:0] i_hi,
  output logic      [7:0] o_val,
  output logic            o_wrap
);
  logic [7:0] val_q;
  logic [7:0] val_d;

  // next value: load, wrap to low limit, or bcd step
  always_comb begin
    val_d  = val_q;
    o_wrap = i_inc & (val_q >= i_hi);
    if (i_load) begin
      val_d = i_load_val;
    end else if (o_wrap) begin
      val_d = i_lo;
    end else if (i_inc) begin
      val_d = rtc_pkg::bcd_inc(val_q);
    end
  end

  // value register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign o_val = val_q;
endmodule

// file: core/rtc_calendar_alarm_regs.sv
// Purpose: real-time-clock calendar, alarm and interrupt register bank on AHB-Lite
// Assumes: i_tick_100hz is asynchronous; event inputs are one-cycle pulses on i_clk
// Notes:   zero-wait-state slave; read data is captured in the address phase
// What this block does
// - low counter word: hundredths 7:0, seconds 14:8, minutes 22:16, hours 29:24, BCD.
// - top bit of upper counter word reports an inconsistent calendar read.
// - century bit changes on its own only when century enable is one.
// - century bit at upper word bit 27: zero means 2000s; writable.
// - hour format bit zero counts 24-hour, one counts 12-hour with AM/PM.
// - tick halt bit one blocks the 100 Hz tick to the counters.
// - repeat field: zero disables alarm; 1..7 yearly down to every second.
// - counter writes are ignored unless the write unlock bit is one.
// - interrupt registers: alarm bit 3, crystal 2, autocal done 1, autocal fail 0.
// - a source raises the interrupt only while its enable bit is set.
// - writing one to the clear register clears that status bit; zeros ignored.
// - writing one to the force register sets status and, if that bit is enabled, raises interrupt at once.
// - status register reads back the latched interrupt causes.
// - two ticks between low and high word reads set read error; high read clears.
// - year wrap 99 to 0 toggles century bit if enabled; leap years use it.
// - alarm flag sets when all counters selected by repeat code match.
// - alarm flag sets on the tick after the matching tick.
`timescale 1ns/100ps
module rtc_calendar_alarm_regs (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  input  wire logic        i_tick_100hz,
  input  wire logic        i_crystal_fail_event,
  input  wire logic        i_autocal_done_event,
  input  wire logic        i_autocal_fail_event,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic      [31:0] o_hrdata,
  output logic             o_irq,
  output logic             o_chain_reset
);
  // bus state
  logic        dp_wr_q, dp_wr_d;
  logic [11:0] dp_addr_q, dp_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q;
  // tick synchroniser
  logic        tick_s1_q, tick_s2_q, tick_s3_q;
  // control and alarm storage
  logic [5:0]  ctl_q, ctl_d;
  logic [31:0] alm_lo_q, alm_lo_d, alm_hi_q, alm_hi_d;
  // hours, century, read error, alarm pending
  logic [5:0]  hour_q, hour_d;
  logic        ceb_q, ceb_d, cb_q, cb_d;
  logic        err_q, err_d, armed_q, armed_d;
  logic [1:0]  tcnt_q, tcnt_d;
  logic        pend_q, pend_d;
  // interrupt state
  logic [3:0]  en_q, en_d, st_q, st_d;
  logic        irq_q, irq_d, crst_q;
  // combinational helpers
  logic        addr_ph, rd_now, wr_low, wr_high, cnt_wr, tick_edge, tick_run;
  logic        wr_clr, wr_set, hi_rd, lo_rd, day_inc, match, leap, alarm_set;
  logic        w_hund, w_sec, w_min, w_date, w_month, w_year;
  logic [7:0]  v_hund, v_sec, v_min, v_date, v_month, v_year, v_wkdy, dmax;
  logic [2:0]  repeat_interval;
  logic [3:0]  hw_ev;
  logic [31:0] cal_low, cal_high;

  assign repeat_interval = ctl_q[rtc_pkg::RPT_LSB +: 3];

  // address phase decode and data phase write strobes
  always_comb begin
    addr_ph = i_hsel & i_htrans[1] & i_hready;
    rd_now  = addr_ph & ~i_hwrite;
    lo_rd   = rd_now & (i_haddr[11:0] == rtc_pkg::ADDR_CAL_LOW);
    hi_rd   = rd_now & (i_haddr[11:0] == rtc_pkg::ADDR_CAL_HIGH);
    wr_low  = dp_wr_q & (dp_addr_q == rtc_pkg::ADDR_CAL_LOW) & ctl_q[rtc_pkg::UNLOCK_BIT];
    wr_high = dp_wr_q & (dp_addr_q == rtc_pkg::ADDR_CAL_HIGH) & ctl_q[rtc_pkg::UNLOCK_BIT];
    cnt_wr  = wr_low | wr_high;
    wr_clr  = dp_wr_q & (dp_addr_q == rtc_pkg::ADDR_IRQ_CLR);
    wr_set  = dp_wr_q & (dp_addr_q == rtc_pkg::ADDR_IRQ_SET);
    dp_wr_d   = addr_ph & i_hwrite;
    dp_addr_d = addr_ph ? i_haddr[11:0] : dp_addr_q;
  end

  // assembled counter words
  always_comb begin
    cal_low  = {2'h0, hour_q, 1'b0, v_min[6:0], 1'b0, v_sec[6:0], v_hund};
    cal_high = {err_q, 2'h0, ceb_q, cb_q, v_wkdy[2:0], v_year, 3'h0, v_month[4:0],
                2'h0, v_date[5:0]};
  end

  // read mux, captured at the address phase; unmapped reads give zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd_now) begin
      case (i_haddr[11:0])
        rtc_pkg::ADDR_CAL_LOW:  rdata_d = cal_low;
        rtc_pkg::ADDR_CAL_HIGH: rdata_d = cal_high;
        rtc_pkg::ADDR_ALM_LOW:  rdata_d = alm_lo_q;
        rtc_pkg::ADDR_ALM_HIGH: rdata_d = alm_hi_q;
        rtc_pkg::ADDR_CTL:      rdata_d = {26'h0, ctl_q};
        rtc_pkg::ADDR_IRQ_EN:   rdata_d = {28'h0, en_q};
        rtc_pkg::ADDR_IRQ_STAT: rdata_d = {28'h0, st_q};
        default:                rdata_d = 32'h0;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 12'h0;
      rdata_q   <= 32'h0;
      ready_q   <= 1'b1;
    end else begin
      dp_wr_q   <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      rdata_q   <= rdata_d;
      ready_q   <= 1'b1;
    end
  end

  // 100 Hz tick: two-flop synchroniser, then rising edge on the second and third stage
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end else begin
      tick_s1_q <= i_tick_100hz;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  // halted or overwritten counters take no tick
  always_comb begin
    tick_edge = tick_s2_q & ~tick_s3_q;
    tick_run  = tick_edge & ~ctl_q[rtc_pkg::HALT_BIT] & ~cnt_wr;
  end

  // calendar counter chain
  rtc_bcd_counter #(.RST_VAL(rtc_pkg::ZERO_RST)) u_hund (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_inc(tick_run), .i_load(wr_low),
    .i_load_val(i_hwdata[7:0]), .i_lo(rtc_pkg::ZERO_RST), .i_hi(rtc_pkg::HUND_MAX),
    .o_val(v_hund), .o_wrap(w_hund));
  rtc_bcd_counter #(.RST_VAL(rtc_pkg::ZERO_RST)) u_sec (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_inc(w_hund), .i_load(wr_low),
    .i_load_val({1'b0, i_hwdata[14:8]}), .i_lo(rtc_pkg::ZERO_RST), .i_hi(rtc_pkg::SEC_MAX),
    .o_val(v_sec), .o_wrap(w_sec));
  rtc_bcd_counter #(.RST_VAL(rtc_pkg::ZERO_RST)) u_min (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_inc(w_sec), .i_load(wr_low),
    .i_load_val({1'b0, i_hwdata[22:16]}), .i_lo(rtc_pkg::ZERO_RST), .i_hi(rtc_pkg::SEC_MAX),
    .o_val(v_min), .o_wrap(w_min));
  rtc_bcd_counter #(.RST_VAL(rtc_pkg::ZERO_RST)) u_date (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_inc(day_inc), .i_load(wr_high),
    .i_load_val({2'h0, i_hwdata[5:0]}), .i_lo(rtc_pkg::ONE_BCD), .i_hi(dmax),
    .o_val(v_date), .o_wrap(w_date));
  rtc_bcd_counter #(.RST_VAL(rtc_pkg::ZERO_RST)) u_wkdy (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_inc(day_inc), .i_load(wr_high),
    .i_load_val({5'h0, i_hwdata[26:24]}), .i_lo(rtc_pkg::ZERO_RST), .i_hi(rtc_pkg::WKDY_MAX),
    .o_val(v_wkdy), .o_wrap());
  rtc_bcd_counter #(.RST_VAL(rtc_pkg::ZERO_RST)) u_month (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_inc(w_date), .i_load(wr_high),
    .i_load_val({3'h0, i_hwdata[12:8]}), .i_lo(rtc_pkg::ONE_BCD), .i_hi(rtc_pkg::MONTH_MAX),
    .o_val(v_month), .o_wrap(w_month));
  rtc_bcd_counter #(.RST_VAL(rtc_pkg::ZERO_RST)) u_year (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_inc(w_month), .i_load(wr_high),
    .i_load_val(i_hwdata[23:16]), .i_lo(rtc_pkg::ZERO_RST), .i_hi(rtc_pkg::YEAR_MAX),
    .o_val(v_year), .o_wrap(w_year));

  // month length with leap years; year 00 is a leap year only in the 2000s
  always_comb begin
    if (v_year[4]) begin
      leap = (v_year[3:0] == 4'h2) | (v_year[3:0] == 4'h6);
    end else begin
      leap = (v_year[3:0] == 4'h0) | (v_year[3:0] == 4'h4) | (v_year[3:0] == 4'h8);
    end
    leap = leap & ((v_year != 8'h00) | ~cb_q);
    case (v_month)
      rtc_pkg::FEB_BCD:            dmax = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11:  dmax = 8'h30;
      default:                     dmax = 8'h31;
    endcase
  end

  // hours in 24-hour or 12-hour form; bit 5 is PM in 12-hour form
  always_comb begin
    hour_d  = hour_q;
    day_inc = 1'b0;
    if (wr_low) begin
      hour_d = i_hwdata[29:24];
    end else if (w_min && !ctl_q[rtc_pkg::HOURFMT_BIT]) begin
      if (hour_q >= rtc_pkg::HR24_MAX) begin
        hour_d  = 6'h00;
        day_inc = 1'b1;
      end else begin
        hour_d = 6'(rtc_pkg::bcd_inc({2'h0, hour_q}));
      end
    end else if (w_min) begin
      if (hour_q[4:0] >= rtc_pkg::HR12_MAX) begin
        hour_d = {hour_q[5], 5'h01};
      end else if (hour_q[4:0] == rtc_pkg::HR12_LAST) begin
        hour_d  = {~hour_q[5], rtc_pkg::HR12_MAX};
        day_inc = hour_q[5];
      end else begin
        hour_d = {hour_q[5], 5'(rtc_pkg::bcd_inc({3'h0, hour_q[4:0]}))};
      end
    end
  end

  // century enable and century bit
  always_comb begin
    ceb_d = ceb_q;
    cb_d  = cb_q;
    if (wr_high) begin
      ceb_d = i_hwdata[rtc_pkg::CEB_BIT];
      cb_d  = i_hwdata[rtc_pkg::CB_BIT];
    end else if (w_year && ceb_q) begin
      cb_d = ~cb_q;
    end
  end

  // read error: armed by a low word read, counts ticks until the high word read
  always_comb begin
    armed_d = armed_q;
    tcnt_d  = tcnt_q;
    if (lo_rd) begin
      armed_d = 1'b1;
      tcnt_d  = 2'h0;
    end else if (hi_rd) begin
      armed_d = 1'b0;
    end else if (armed_q && tick_run && tcnt_q != 2'h2) begin
      tcnt_d = tcnt_q + 2'h1;
    end
    err_d = (err_q & ~hi_rd) | (armed_q & tick_run & (tcnt_q == 2'h1));
  end

  // alarm compare selected by the repeat code
  always_comb begin
    match = (repeat_interval != rtc_pkg::RPT_OFF) & (v_hund == alm_lo_q[7:0]);
    if (repeat_interval <= rtc_pkg::RPT_MIN) begin
      match = match & (v_sec[6:0] == alm_lo_q[14:8]);
    end
    if (repeat_interval <= rtc_pkg::RPT_HOUR) begin
      match = match & (v_min[6:0] == alm_lo_q[22:16]);
    end
    if (repeat_interval <= rtc_pkg::RPT_DAY) begin
      match = match & (hour_q == alm_lo_q[29:24]);
    end
    if (repeat_interval == rtc_pkg::RPT_WEEK) begin
      match = match & (v_wkdy[2:0] == alm_hi_q[18:16]);
    end
    if (repeat_interval == rtc_pkg::RPT_YEAR || repeat_interval == rtc_pkg::RPT_MONTH) begin
      match = match & (v_date[5:0] == alm_hi_q[5:0]);
    end
    if (repeat_interval == rtc_pkg::RPT_YEAR) begin
      match = match & (v_month[4:0] == alm_hi_q[12:8]);
    end
    // remember that the counters already stand on the alarm, so the next tick raises the flag
    pend_d    = match;
    alarm_set = tick_run & pend_q & (repeat_interval != rtc_pkg::RPT_OFF);
  end

  // control, alarm, enable and status registers
  always_comb begin
    ctl_d    = ctl_q;
    alm_lo_d = alm_lo_q;
    alm_hi_d = alm_hi_q;
    en_d     = en_q;
    if (dp_wr_q && dp_addr_q == rtc_pkg::ADDR_CTL) begin
      ctl_d = i_hwdata[5:0];
    end
    if (dp_wr_q && dp_addr_q == rtc_pkg::ADDR_ALM_LOW) begin
      alm_lo_d = i_hwdata & rtc_pkg::MASK_CAL_LOW;
    end
    if (dp_wr_q && dp_addr_q == rtc_pkg::ADDR_ALM_HIGH) begin
      alm_hi_d = i_hwdata & rtc_pkg::MASK_ALM_HIGH;
    end
    if (dp_wr_q && dp_addr_q == rtc_pkg::ADDR_IRQ_EN) begin
      en_d = i_hwdata[3:0];
    end
    hw_ev = {alarm_set, i_crystal_fail_event, i_autocal_done_event, i_autocal_fail_event};
    st_d  = st_q & ~(wr_clr ? i_hwdata[3:0] : 4'h0);
    st_d  = st_d | hw_ev | (wr_set ? i_hwdata[3:0] : 4'h0);
    irq_d = |(st_d & en_d);
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_q    <= 6'h00;
      alm_lo_q <= 32'h0;
      alm_hi_q <= 32'h0;
      hour_q   <= 6'(rtc_pkg::HOUR_RST);
      ceb_q    <= 1'b0;
      cb_q     <= 1'b0;
      err_q    <= 1'b0;
      armed_q  <= 1'b0;
      tcnt_q   <= 2'h0;
      pend_q   <= 1'b0;
      en_q     <= 4'h0;
      st_q     <= 4'h0;
      irq_q    <= 1'b0;
      crst_q   <= 1'b0;
    end else begin
      ctl_q    <= ctl_d;
      alm_lo_q <= alm_lo_d;
      alm_hi_q <= alm_hi_d;
      hour_q   <= hour_d;
      ceb_q    <= ceb_d;
      cb_q     <= cb_d;
      err_q    <= err_d;
      armed_q  <= armed_d;
      tcnt_q   <= tcnt_d;
      pend_q   <= pend_d;
      en_q     <= en_d;
      st_q     <= st_d;
      irq_q    <= irq_d;
      crst_q   <= cnt_wr;
    end
  end

  // outputs, all from flops
  assign o_hreadyout   = ready_q;
  assign o_hresp       = 1'b0 & ready_q;
  assign o_hrdata      = rdata_q;
  assign o_irq         = irq_q;
  assign o_chain_reset = crst_q;

  default clocking cb_main @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_low_reserved: assert property (lo_rd |=> (o_hrdata & ~rtc_pkg::MASK_CAL_LOW) == 32'h0)
    else $error("reserved bits of low counter word read nonzero");
  a_err_report: assert property (hi_rd && err_q |=> o_hrdata[rtc_pkg::ERR_BIT])
    else $error("read error not reported");
  a_century_hold: assert property (!ceb_q && !wr_high |=> $stable(cb_q))
    else $error("century bit changed while disabled");
  a_halt_blocks: assert property (ctl_q[rtc_pkg::HALT_BIT] && !wr_low |=> $stable(v_hund))
    else $error("counters ran while halted");
  a_locked_write: assert property (dp_wr_q && dp_addr_q == rtc_pkg::ADDR_CAL_HIGH
                    && !ctl_q[rtc_pkg::UNLOCK_BIT] && !tick_run |=> $stable(v_year))
    else $error("locked counter write took effect");
  a_err_clear: assert property (hi_rd && !tick_run |=> !err_q)
    else $error("high word read did not clear read error");
  a_alarm_delay: assert property (tick_run && !pend_q |-> !alarm_set)
    else $error("alarm match not held for next tick");
  a_alarm_sets: assert property (alarm_set |=> st_q[rtc_pkg::IRQ_ALARM])
    else $error("alarm event lost");
  a_clear_works: assert property (wr_clr && i_hwdata[0] && !i_autocal_fail_event
                    |=> !st_q[rtc_pkg::IRQ_ACFAIL])
    else $error("write one to clear failed");
  a_force_irq: assert property (wr_set && i_hwdata[1] && en_q[1]
                    |=> st_q[rtc_pkg::IRQ_ACDONE] && o_irq)
    else $error("forced interrupt not raised");
  a_irq_gate: assert property (o_irq == (|(st_q & en_q)))
    else $error("interrupt without enabled status");
endmodule

// file: core/rtc_pkg.sv
// Purpose: shared constants for the calendar / alarm register bank
// Assumes: 32-bit AHB-Lite data, registers decoded on byte address bits 11:0
// Notes:   all counter values are packed BCD
package rtc_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_CAL_LOW  = 12'h040;
  localparam logic [11:0] ADDR_CAL_HIGH = 12'h044;
  localparam logic [11:0] ADDR_ALM_LOW  = 12'h048;
  localparam logic [11:0] ADDR_ALM_HIGH = 12'h04c;
  localparam logic [11:0] ADDR_CTL      = 12'h050;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h100;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h104;
  localparam logic [11:0] ADDR_IRQ_CLR  = 12'h108;
  localparam logic [11:0] ADDR_IRQ_SET  = 12'h10c;
  // calendar high word fields
  localparam int ERR_BIT   = 31;
  localparam int CEB_BIT   = 28;
  localparam int CB_BIT    = 27;
  // control register fields
  localparam int HOURFMT_BIT = 5;
  localparam int HALT_BIT    = 4;
  localparam int RPT_LSB     = 1;
  localparam int UNLOCK_BIT  = 0;
  // interrupt source positions
  localparam int IRQ_ALARM   = 3;
  localparam int IRQ_CRYSTAL = 2;
  localparam int IRQ_ACDONE  = 1;
  localparam int IRQ_ACFAIL  = 0;
  // writable-field masks, reserved bits read zero
  localparam logic [31:0] MASK_CAL_LOW  = 32'h3f7f7fff;
  localparam logic [31:0] MASK_CAL_HIGH = 32'h1fff1f3f;
  localparam logic [31:0] MASK_ALM_HIGH = 32'h00071f3f;
  // reset values
  localparam logic [7:0] HOUR_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // bcd limits
  localparam logic [7:0] HUND_MAX  = 8'h99;
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] WKDY_MAX  = 8'h06;
  localparam logic [7:0] ONE_BCD   = 8'h01;
  localparam logic [7:0] FEB_BCD   = 8'h02;
  localparam logic [5:0] HR24_MAX  = 6'h23;
  localparam logic [4:0] HR12_MAX  = 5'h12;
  localparam logic [4:0] HR12_LAST = 5'h11;
  // alarm repeat codes
  localparam logic [2:0] RPT_OFF   = 3'h0;
  localparam logic [2:0] RPT_YEAR  = 3'h1;
  localparam logic [2:0] RPT_MONTH = 3'h2;
  localparam logic [2:0] RPT_WEEK  = 3'h3;
  localparam logic [2:0] RPT_DAY   = 3'h4;
  localparam logic [2:0] RPT_HOUR  = 3'h5;
  localparam logic [2:0] RPT_MIN   = 3'h6;

  // one bcd step with decimal carry from the ones digit
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction
endpackage

// file: tb/rtc_calendar_alarm_regs_tb.sv
// Purpose: self-checking bench for the calendar, alarm and interrupt register bank
// Assumes: single zero-wait slave, hready looped back from hreadyout
// Notes:   ticks are slow pulses on the 100 Hz pin, several clocks high and low
`timescale 1ns/100ps
module rtc_calendar_alarm_regs_tb;
  logic        i_clk   = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        tk      = 1'b0;
  logic [2:0]  ev      = 3'h0;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  int          fails       = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  logic [31:0] rv;
  // rollover cases: control, counters in, counters expected after one tick
  logic [31:0] ctl_v[3] = '{32'h0, 32'h0, 32'h20};
  logic [31:0] lo_in[3] = '{32'h23595999, 32'h23595999, 32'h11595999};
  logic [31:0] lo_ex[3] = '{32'h0, 32'h0, 32'h32000000};
  logic [31:0] hi_in[3] = '{32'h10991231, 32'h00991231, 32'h00991231};
  logic [31:0] hi_ex[3] = '{32'h19000101, 32'h01000101, 32'h00991231};

  // 25 MHz clock
  always #20 i_clk = ~i_clk;

  rtc_calendar_alarm_regs rtc_calendar_alarm_regs_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .i_tick_100hz(tk),
    .i_crystal_fail_event(ev[2]), .i_autocal_done_event(ev[1]), .i_autocal_fail_event(ev[0]),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .o_irq(irq), .o_chain_reset()
  );

  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rv);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rv);
    chk(rv, e);
  endtask

  // one 100 Hz tick, held several clocks high and low
  task automatic tick;
    tk <= 1'b1;
    repeat (4) @(posedge i_clk);
    tk <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge i_clk);
    ev <= 3'h0;
    @(posedge i_clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rchk(rtc_pkg::ADDR_CAL_LOW, 32'h01000000);
    rchk(rtc_pkg::ADDR_CAL_HIGH, 32'h0);
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h0);
    wr(rtc_pkg::ADDR_CAL_LOW, 32'h12345678);
    rchk(rtc_pkg::ADDR_CAL_LOW, 32'h01000000);
    wr(12'h200, 32'hffffffff);
    rchk(12'h200, 32'h0);
    rchk(rtc_pkg::ADDR_IRQ_CLR, 32'h0);
    $display("test reset_and_lock done");
    // halted tick, then a running tick across the day, year and century edge, or across the 12-hour noon edge
    for (int i = 0; i < 3; i++) begin
      wr(rtc_pkg::ADDR_CTL, ctl_v[i] | 32'h1);
      wr(rtc_pkg::ADDR_CAL_LOW, lo_in[i]);
      wr(rtc_pkg::ADDR_CAL_HIGH, hi_in[i]);
      rchk(rtc_pkg::ADDR_CAL_HIGH, hi_in[i]);
      wr(rtc_pkg::ADDR_CTL, ctl_v[i] | 32'h10);
      tick();
      rchk(rtc_pkg::ADDR_CAL_LOW, lo_in[i]);
      wr(rtc_pkg::ADDR_CTL, ctl_v[i]);
      tick();
      rchk(rtc_pkg::ADDR_CAL_LOW, lo_ex[i]);
      rchk(rtc_pkg::ADDR_CAL_HIGH, hi_ex[i]);
    end
    $display("test rollover done");
    // one tick between the word reads is fine, two flag an error
    for (int n = 1; n < 3; n++) begin
      bus(1'b0, rtc_pkg::ADDR_CAL_LOW, 32'h0, rv);
      repeat (n) tick();
      bus(1'b0, rtc_pkg::ADDR_CAL_HIGH, 32'h0, rv);
      chk({31'h0, rv[31]}, (n == 2) ? 32'h1 : 32'h0);
      bus(1'b0, rtc_pkg::ADDR_CAL_HIGH, 32'h0, rv);
      chk({31'h0, rv[31]}, 32'h0);
    end
    $display("test read_error done");
    // per-second alarm on hundredths 01, flag one tick later
    wr(rtc_pkg::ADDR_CTL, 32'h1);
    wr(rtc_pkg::ADDR_CAL_LOW, 32'h0);
    wr(rtc_pkg::ADDR_ALM_LOW, 32'h1);
    wr(rtc_pkg::ADDR_CTL, 32'he);
    wr(rtc_pkg::ADDR_IRQ_EN, 32'h8);
    tick();
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h0);
    tick();
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h8);
    irq_is(1'b1);
    wr(rtc_pkg::ADDR_CTL, 32'h0);
    wr(rtc_pkg::ADDR_IRQ_CLR, 32'h8);
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h0);
    $display("test alarm done");
    // enable, hardware events, force and clear
    wr(rtc_pkg::ADDR_IRQ_EN, 32'hffffffff);
    rchk(rtc_pkg::ADDR_IRQ_EN, 32'hf);
    wr(rtc_pkg::ADDR_IRQ_EN, 32'h4);
    pulse(3'h2);
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h2);
    irq_is(1'b0);
    wr(rtc_pkg::ADDR_IRQ_SET, 32'h4);
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h6);
    irq_is(1'b1);
    wr(rtc_pkg::ADDR_IRQ_CLR, 32'h2);
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h4);
    wr(rtc_pkg::ADDR_IRQ_CLR, 32'h4);
    irq_is(1'b0);
    pulse(3'h4);
    irq_is(1'b1);
    pulse(3'h1);
    rchk(rtc_pkg::ADDR_IRQ_STAT, 32'h5);
    $display("test interrupts done");
    results();
  end
endmodule
